// ---- src/tssc_client.sv ----
/*
  Device end: two-wire client with fixed address, register pointer,
  write strobe and read fetch toward the register file of the device.
  Assumes the register file answers REG_RDATA combinationally from REG_ADDR.
*/
`timescale 1ns/10ps
module tssc_client
  import tssc_pkg::*;
(
  input wire logic MCLK,
  input wire logic NRST,
  tssc_bus_if.device BUS,
  input wire logic TIMEOUT_EN,
  input wire logic [7:0] REG_RDATA,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WE,
  output logic BUSY
);
  import tssc_pkg::*;

  typedef enum {
    S_IDLE,
    S_ADDR,
    S_ACK_ADDR,
    S_PTR,
    S_ACK_PTR,
    S_WDATA,
    S_ACK_WDATA,
    S_RDATA,
    S_RACK
  } tssc_state_type;

  tssc_state_type state_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_q;
  logic sda_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic sda_low_q;
  logic full_q;
  logic [CNT_W-1:0] low_cnt_q;
  logic [CNT_W-1:0] idle_cnt_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic tmo_reset;
  logic last_bit;

  // Two-flop synchronisers, then one stage for edge detect
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], BUS.serial_clock_pin};
      sda_sync_q <= {sda_sync_q[0], BUS.sda};
      scl_q <= scl_sync_q[1];
      sda_q <= sda_sync_q[1];
    end
  end

  assign scl_rise = scl_sync_q[1] & ~scl_q;
  assign scl_fall = ~scl_sync_q[1] & scl_q;
  assign start_det = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
  assign stop_det = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];
  assign last_bit = (bit_q == 3'(BYTE_BITS - 1));

  // Whole byte received; keeps the clock fall after a start from being taken as a byte end
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      full_q <= 1'b0;
    end else if (tmo_reset || stop_det || start_det || scl_fall) begin
      full_q <= 1'b0;
    end else if (scl_rise && last_bit && (state_q == S_ADDR || state_q == S_PTR || state_q == S_WDATA)) begin
      full_q <= 1'b1;
    end
  end

  // Clock-low and bus-idle counters, active only with enable
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      low_cnt_q <= '0;
      idle_cnt_q <= '0;
    end else begin
      low_cnt_q <= (TIMEOUT_EN && !scl_q) ? low_cnt_q + 1'b1 : '0;
      idle_cnt_q <= (TIMEOUT_EN && scl_q && sda_q) ? idle_cnt_q + 1'b1 : '0;
    end
  end

  assign tmo_reset = (low_cnt_q >= CNT_W'(TIMEOUT_CYCLES))
    || (idle_cnt_q > CNT_W'(IDLE_CYCLES));

  // Protocol state, bit counter and shifter
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= S_IDLE;
      bit_q <= '0;
      shift_q <= '0;
    end else if (tmo_reset || stop_det) begin
      state_q <= S_IDLE;
    end else if (start_det) begin
      state_q <= S_ADDR;
      bit_q <= '0;
    end else if (scl_rise) begin
      unique case (state_q)
        S_ADDR, S_PTR, S_WDATA: begin
          shift_q <= {shift_q[6:0], sda_q};
          bit_q <= bit_q + 1'b1;
        end
        S_RACK: begin
          if (sda_q) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_q)
        S_ADDR: begin
          if (full_q) begin
            // Compare only the fixed address; general call and alert get no answer
            state_q <= (shift_q[7:1] == CLIENT_ADDR) ? S_ACK_ADDR : S_IDLE;
          end
        end
        S_PTR, S_WDATA: begin
          if (full_q) begin
            state_q <= (state_q == S_PTR) ? S_ACK_PTR : S_ACK_WDATA;
          end
        end
        S_ACK_ADDR: begin
          state_q <= shift_q[0] ? S_RDATA : S_PTR;
        end
        S_ACK_PTR, S_ACK_WDATA: begin
          state_q <= S_WDATA;
        end
        S_RDATA: begin
          bit_q <= bit_q + 1'b1;
          if (last_bit) begin
            state_q <= S_RACK;
          end
        end
        S_RACK: begin
          state_q <= S_RDATA;
        end
        default: begin
        end
      endcase
    end
  end

  // Register pointer: never reset by the protocol, only by NRST
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ptr_q <= PTR_RESET;
    end else if (scl_fall && full_q && !stop_det && !start_det && !tmo_reset) begin
      if (state_q == S_PTR) begin
        ptr_q <= shift_q;
      end else if (state_q == S_WDATA) begin
        ptr_q <= ptr_q + 1'b1;
      end
    end else if (scl_fall && state_q == S_RDATA && last_bit && !stop_det && !tmo_reset) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // Write strobe follows the byte by one cycle, after the pointer has already advanced past it
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      REG_WE <= 1'b0;
      REG_WDATA <= '0;
    end else begin
      REG_WE <= scl_fall && state_q == S_WDATA && full_q && !stop_det && !start_det && !tmo_reset;
      REG_WDATA <= shift_q;
    end
  end

  // Data line driver, changed only while clock is low
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sda_low_q <= 1'b0;
    end else if (tmo_reset || stop_det || start_det) begin
      sda_low_q <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_q)
        S_ADDR: sda_low_q <= full_q && (shift_q[7:1] == CLIENT_ADDR);
        S_PTR, S_WDATA: sda_low_q <= full_q;
        S_ACK_ADDR: sda_low_q <= shift_q[0] ? ~REG_RDATA[7] : 1'b0;
        S_RDATA: sda_low_q <= last_bit ? 1'b0 : ~REG_RDATA[3'(6) - bit_q];
        S_RACK: sda_low_q <= ~REG_RDATA[7];
        default: sda_low_q <= 1'b0;
      endcase
    end
  end

  assign REG_ADDR = ptr_q;
  assign BUS.sda_oe_n_dev = ~sda_low_q;
  assign BUS.scl_oe_n_dev = 1'b1;
  assign BUSY = (state_q != S_IDLE);
endmodule

// ---- pkg/tssc_pkg.sv ----
/*
  Shared constants and types for the two-wire touch sensor serial client
  and its bus master end. Assumes a single 50 MHz clock on both ends.
*/
package tssc_pkg;
  localparam int CLK_FREQ_HZ = 50000000;
  // Client address 0101000 and direction bit values
  localparam logic [6:0] CLIENT_ADDR = 7'h28;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam int BYTE_BITS = 8;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Clock-low timeout and idle limit, in their own units
  localparam int TIMEOUT_MS = 30;
  localparam int IDLE_US = 200;
  localparam int TIMEOUT_CYCLES = (CLK_FREQ_HZ / 1000) * TIMEOUT_MS;
  localparam int IDLE_CYCLES = (CLK_FREQ_HZ / 1000000) * IDLE_US;
  // Host serial clock: 100 kHz, quarter bit period in cycles
  localparam int SCL_KHZ = 100;
  localparam int HALF_CYCLES = CLK_FREQ_HZ / (SCL_KHZ * 4000);
  localparam int CNT_W = 24;
  // Host command kinds
  typedef enum logic [1:0] {
    TSSC_CMD_WRITE,
    TSSC_CMD_READ,
    TSSC_CMD_SEND,
    TSSC_CMD_RECV
  } tssc_cmd_type;
endpackage

// ---- pkg/tssc_bus_if.sv ----
/*
  Two-wire bus between client and host. Each party drives the line low
  when its enable is low; the resolved level is the AND of both drivers
  and of the line pulled high.
*/
`timescale 1ns/10ps
interface tssc_bus_if;
  logic scl_oe_n_host;
  logic sda_oe_n_host;
  logic sda_oe_n_dev;
  logic scl_oe_n_dev;
  logic serial_clock_pin;
  logic sda;
  // Wired-AND of both open-drain drivers
  assign serial_clock_pin = scl_oe_n_host & scl_oe_n_dev;
  assign sda = sda_oe_n_host & sda_oe_n_dev;
  modport device (input serial_clock_pin, input sda, output sda_oe_n_dev, output scl_oe_n_dev);
  modport host (input serial_clock_pin, input sda, output scl_oe_n_host, output sda_oe_n_host);
endinterface

// ---- src/tssc_host.sv ----
/*
  Host end: bus master issuing write, read, send and receive byte
  transactions. One command at a time, taken with CMD_VALID and CMD_READY.
  Assumes the client never stretches the clock.
*/
`timescale 1ns/10ps
module tssc_host
  import tssc_pkg::*;
(
  input wire logic MCLK,
  input wire logic NRST,
  tssc_bus_if.host BUS,
  input wire logic CMD_VALID,
  input tssc_pkg::tssc_cmd_type CMD_KIND,
  input wire logic [7:0] CMD_REG,
  input wire logic [7:0] CMD_DATA,
  output logic CMD_READY,
  output logic DONE,
  output logic NACKED,
  output logic [7:0] RDATA
);
  import tssc_pkg::*;

  typedef enum {
    H_IDLE,
    H_START,
    H_BIT,
    H_STOP,
    H_FREE
  } tssc_hstate_type;

  tssc_hstate_type state_q;
  tssc_cmd_type kind_q;
  logic [7:0] reg_q;
  logic [7:0] data_q;
  logic [7:0] tx_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [1:0] phase_q;
  logic [15:0] cnt_q;
  logic scl_n_q;
  logic sda_n_q;
  logic [1:0] sda_sync_q;
  logic nack_q;
  logic rd_byte;
  logic tick;

  // Byte of a read-direction phase: host samples instead of drives
  assign rd_byte = (kind_q == TSSC_CMD_RECV && byte_q == 2'h1)
    || (kind_q == TSSC_CMD_READ && byte_q == 2'h3);
  assign tick = (cnt_q == 16'(HALF_CYCLES - 1));

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sda_sync_q <= 2'h3;
    end else begin
      sda_sync_q <= {sda_sync_q[0], BUS.sda};
    end
  end

  // Bit engine: four quarter phases per bit at a steady 100 kHz
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= H_IDLE;
      kind_q <= TSSC_CMD_WRITE;
      reg_q <= '0;
      data_q <= '0;
      tx_q <= '0;
      bit_q <= '0;
      byte_q <= '0;
      phase_q <= '0;
      cnt_q <= '0;
      scl_n_q <= 1'b0;
      sda_n_q <= 1'b0;
      nack_q <= 1'b0;
      RDATA <= '0;
      DONE <= 1'b0;
    end else begin
      DONE <= 1'b0;
      cnt_q <= tick ? '0 : cnt_q + 1'b1;
      unique case (state_q)
        H_IDLE: begin
          cnt_q <= '0;
          if (CMD_VALID) begin
            kind_q <= CMD_KIND;
            reg_q <= CMD_REG;
            data_q <= CMD_DATA;
            tx_q <= {CLIENT_ADDR, (CMD_KIND == TSSC_CMD_RECV) ? DIR_READ : DIR_WRITE};
            byte_q <= '0;
            bit_q <= '0;
            phase_q <= '0;
            nack_q <= 1'b0;
            state_q <= H_START;
          end
        end
        H_START: if (tick) begin
          // Data falls while clock high, then clock low
          phase_q <= phase_q + 1'b1;
          if (phase_q == 2'h0) begin
            scl_n_q <= 1'b0;
            sda_n_q <= 1'b0;
          end else if (phase_q == 2'h1) begin
            sda_n_q <= 1'b1;
          end else if (phase_q == 2'h2) begin
            scl_n_q <= 1'b1;
            phase_q <= '0;
            bit_q <= '0;
            state_q <= H_BIT;
          end
        end
        H_BIT: if (tick) begin
          phase_q <= phase_q + 1'b1;
          unique case (phase_q)
            2'h0: begin
              if (bit_q < 4'h8) begin
                sda_n_q <= rd_byte ? 1'b0 : ~tx_q[7];
              end else begin
                // Release data in the ack slot: every read byte ends in NACK, write bytes are left to the client
                sda_n_q <= rd_byte ? 1'b0 : 1'b0;
              end
            end
            2'h1: scl_n_q <= 1'b0;
            2'h2: begin
              if (bit_q < 4'h8) begin
                if (rd_byte) begin
                  RDATA <= {RDATA[6:0], sda_sync_q[1]};
                end
                tx_q <= {tx_q[6:0], 1'b0};
              end else if (!rd_byte && sda_sync_q[1]) begin
                nack_q <= 1'b1;
              end
            end
            default: begin
              scl_n_q <= 1'b1;
              if (bit_q == 4'h8) begin
                bit_q <= '0;
                byte_q <= byte_q + 1'b1;
                if (nack_q || rd_byte || (kind_q == TSSC_CMD_SEND && byte_q == 2'h1)
                    || (kind_q == TSSC_CMD_WRITE && byte_q == 2'h2)) begin
                  state_q <= H_STOP;
                end else if (kind_q == TSSC_CMD_READ && byte_q == 2'h1) begin
                  tx_q <= {CLIENT_ADDR, DIR_READ};
                  sda_n_q <= 1'b0;
                  state_q <= H_START;
                end else begin
                  tx_q <= (byte_q == 2'h0) ? reg_q : data_q;
                end
              end else begin
                bit_q <= bit_q + 1'b1;
              end
            end
          endcase
        end
        H_STOP: if (tick) begin
          // Data low, clock up, then data rises while clock high
          phase_q <= phase_q + 1'b1;
          if (phase_q == 2'h0) begin
            sda_n_q <= 1'b1;
          end else if (phase_q == 2'h1) begin
            scl_n_q <= 1'b0;
          end else if (phase_q == 2'h2) begin
            sda_n_q <= 1'b0;
            phase_q <= '0;
            state_q <= H_FREE;
          end
        end
        default: if (tick) begin
          phase_q <= phase_q + 1'b1;
          if (phase_q == 2'h3) begin
            DONE <= 1'b1;
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Enables low means the line is pulled down
  assign BUS.scl_oe_n_host = ~scl_n_q;
  assign BUS.sda_oe_n_host = ~sda_n_q;
  assign CMD_READY = (state_q == H_IDLE);
  assign NACKED = nack_q;
endmodule

// ---- test/tssc_bus_checker.sv ----
/*
  Wire checker for the two-wire bus between host and client ends.
  Assumes one clock domain and the signals of the shared bus interface.
*/
`timescale 1ns/10ps
module tssc_bus_checker (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic scl_oe_n_host,
  input wire logic sda_oe_n_host,
  input wire logic sda_oe_n_dev,
  input wire logic scl_oe_n_dev,
  input wire logic serial_clock_pin,
  input wire logic sda
);
  logic [1:0] lines_q;
  logic [3:0] cnt_q;
  logic first_q;
  logic dir_q;
  logic seen_q;
  logic start;
  logic stop;
  logic rise;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // Bus events from last and present line levels
  assign start = lines_q[1] & serial_clock_pin & lines_q[0] & ~sda;
  assign stop = lines_q[1] & serial_clock_pin & ~lines_q[0] & sda;
  assign rise = serial_clock_pin & ~lines_q[1];
  // Line history
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      lines_q <= 2'h3;
    end else begin
      lines_q <= {serial_clock_pin, sda};
    end
  end
  // Bit slot count, first byte and direction
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cnt_q <= 4'h0;
      first_q <= 1'b1;
      dir_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (start) begin
      cnt_q <= 4'h0;
      first_q <= 1'b1;
      seen_q <= 1'b1;
    end else if (rise) begin
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h8) begin
        first_q <= 1'b0;
      end
      if (cnt_q == 4'h7 && first_q) begin
        dir_q <= sda;
      end
    end
  end
  a_no_clock_stretch: assert property (scl_oe_n_dev)
    else $error("client pulled the clock low");
  a_no_dev_edges: assert property (serial_clock_pin && lines_q[1] |-> $stable(sda_oe_n_dev))
    else $error("client moved data while clock high");
  a_addr_released: assert property (start |-> sda_oe_n_dev [*8])
    else $error("client drove data after start");
  a_ack_ninth: assert property (rise && cnt_q == 4'h8 && (first_q || !dir_q) |-> !sda)
    else $error("byte not acknowledged");
  a_nack_final: assert property (rise && cnt_q == 4'h8 && !first_q && dir_q |-> sda)
    else $error("final read byte acknowledged");
  a_stop_release: assert property (stop |=> (sda_oe_n_dev && sda) [*8])
    else $error("data held after stop");
  a_byte_framing: assert property (seen_q && (start || stop) |-> cnt_q == 4'h1)
    else $error("frame not made of whole bytes");
  a_clock_low_bound: assert property ($fell(serial_clock_pin) |-> ##[1:1000] serial_clock_pin)
    else $error("clock low too long");
endmodule

// ---- test/touch_sensor_serial_client_test.sv ----
/*
  Self-checking bench joining host and client ends over the shared bus.
  Assumes a register file model that answers the client at once.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module touch_sensor_serial_client_test;
  import tssc_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic timeout_en = 1'b0;
  logic cmd_valid = 1'b0;
  tssc_cmd_type cmd_kind = TSSC_CMD_WRITE;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] rdata;
  logic reg_we;
  logic busy;
  logic cmd_ready;
  logic done;
  logic nacked;
  logic [7:0] mem [256];
  int error_cnt = 0;
  int samples_checked = 0;
  int we_cnt = 0;
  int cycles = 0;
  tssc_bus_if tssc_bus_if_inst ();
  tssc_client tssc_client_inst (.MCLK(mclk), .NRST(nrst), .BUS(tssc_bus_if_inst), .TIMEOUT_EN(timeout_en),
    .REG_RDATA(reg_rdata), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we), .BUSY(busy));
  tssc_host tssc_host_inst (.MCLK(mclk), .NRST(nrst), .BUS(tssc_bus_if_inst), .CMD_VALID(cmd_valid),
    .CMD_KIND(cmd_kind), .CMD_REG(cmd_reg), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .DONE(done),
    .NACKED(nacked), .RDATA(rdata));
  tssc_bus_checker tssc_bus_checker_inst (.MCLK(mclk), .NRST(nrst),
    .scl_oe_n_host(tssc_bus_if_inst.scl_oe_n_host), .sda_oe_n_host(tssc_bus_if_inst.sda_oe_n_host),
    .sda_oe_n_dev(tssc_bus_if_inst.sda_oe_n_dev), .scl_oe_n_dev(tssc_bus_if_inst.scl_oe_n_dev),
    .serial_clock_pin(tssc_bus_if_inst.serial_clock_pin), .sda(tssc_bus_if_inst.sda));
  // Clock, 20 ns period
  always #10 mclk = ~mclk;
  // Register file model, read at once from the pointer
  assign reg_rdata = mem[reg_addr];
  // Store strobe lands one below the already advanced pointer; run limit
  always @(posedge mclk) begin
    cycles++;
    if (reg_we) begin
      mem[reg_addr - 8'h01] <= reg_wdata;
      we_cnt++;
    end
    if (cycles == 90000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Counts, verdict and end of run
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One host command, then wait for its end pulse
  task automatic run_cmd(input tssc_cmd_type k, input logic [7:0] r, input logic [7:0] d);
    int n;
    cmd_kind <= k;
    cmd_reg <= r;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
  endtask
  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // Write to the top register, pointer wraps
    run_cmd(TSSC_CMD_WRITE, 8'hFF, 8'hA5);
    `CHK(nacked, 1'b0)
    `CHK(we_cnt, 1)
    `CHK(mem[8'hFF], 8'hA5)
    `CHK(reg_addr, 8'h00)
    // Pointer only, nothing stored
    run_cmd(TSSC_CMD_SEND, 8'h10, 8'h00);
    `CHK(reg_addr, 8'h10)
    `CHK(we_cnt, 1)
    // Reads from the held pointer
    run_cmd(TSSC_CMD_RECV, 8'h00, 8'h00);
    `CHK(rdata, 8'h4A)
    `CHK(reg_addr, 8'h11)
    timeout_en <= 1'b1;
    run_cmd(TSSC_CMD_RECV, 8'h00, 8'h00);
    `CHK(rdata, 8'h4B)
    // Addressed read of the written top register
    run_cmd(TSSC_CMD_READ, 8'hFF, 8'h00);
    `CHK(rdata, 8'hA5)
    `CHK(reg_addr, 8'h00)
    `CHK(busy, 1'b0)
    report_and_stop();
  end
endmodule
